/* design/pdtc_pkg.sv */
package pdtc_pkg;
	// register indices on the serial port
	localparam logic [2:0] RI_CTRL = 3'h0;
	localparam logic [2:0] RI_PER_LO = 3'h1;
	localparam logic [2:0] RI_PULSE_HI = 3'h2;
	localparam logic [2:0] RI_PULSE_LO = 3'h3;
	localparam logic [2:0] RI_WIDTH = 3'h4;
	localparam logic [2:0] RI_SHIFT = 3'h5;
	localparam logic [2:0] RI_OFFS = 3'h6;
	localparam logic [2:0] RI_HYB = 3'h7;
	localparam logic [7:0] REG_COUNT = 8'h08;
	// field positions
	localparam int CTRL_CN_HI = 3;
	localparam int CTRL_CN_LO = 2;
	localparam int CTRL_P1 = 1;
	localparam int CTRL_P2 = 0;
	localparam int PH_PER_MSB = 7;
	localparam int PH_DIR = 6;
	localparam int OFF_IDLE = 7;
	localparam int OFF_HB = 6;
	localparam int OFF_HYB = 5;
	localparam int CFG_CC = 16;
	// reset values
	localparam logic [7:0] CTRL_RST = 8'h63;
	localparam logic [7:0] HYB_RST = 8'h80;
	// ahb-lite register byte offsets
	localparam logic [7:0] AHB_STATUS = 8'h00;
	localparam logic [7:0] AHB_CONFIG = 8'h04;
	// oscillator: one tick is 40 ps*1000, clock is 50 ns
	localparam int OSC_PERIOD_PS = 40000;
	localparam int CLK_PERIOD_PS = 50000;
	localparam int FRAC_BITS = 12;
	localparam logic [13:0] OSC_INC_NOM = 14'((2**FRAC_BITS) * CLK_PERIOD_PS / OSC_PERIOD_PS);
	// tracking range in oscillator ticks
	localparam int F_MIN_KHZ = 50;
	localparam int F_MAX_KHZ = 200;
	localparam longint PS_PER_KHZ = 64'd1000000000;
	localparam logic [8:0] PER_MIN = 9'(PS_PER_KHZ / (F_MAX_KHZ * OSC_PERIOD_PS / 1000) / 1000);
	localparam logic [8:0] PER_MAX = 9'(PS_PER_KHZ / (F_MIN_KHZ * OSC_PERIOD_PS / 1000) / 1000);
	// supply thresholds in mV
	localparam logic [12:0] HB_RISE_MV = 13'd4500;
	localparam logic [12:0] HB_HYST_MV = 13'd100;
	localparam logic [12:0] HB_FALL_MV = 13'(HB_RISE_MV - HB_HYST_MV);
	// calibration shape
	localparam logic signed [7:0] SWEEP_SPAN = 8'sh40;
	localparam logic signed [7:0] CAL_STEP = 8'sh04;
	localparam logic [3:0] CAL_DWELL = 4'h4;
	localparam logic [3:0] INC_STEPS = 4'h8;
	typedef enum logic [1:0] {
		CN_NONE = 2'b00,
		CN_INC = 2'b01,
		CN_SWEEP = 2'b10,
		CN_RSVD = 2'b11
	} pdtc_cn_t;
	typedef enum logic [1:0] {
		CAL_IDLE = 2'b00,
		CAL_SWEEP = 2'b01,
		CAL_INC = 2'b10
	} pdtc_cal_t;
	typedef enum logic [2:0] {
		I2C_IDLE = 3'b000,
		I2C_ADDR = 3'b001,
		I2C_ACK_A = 3'b010,
		I2C_REG = 3'b011,
		I2C_ACK_R = 3'b100,
		I2C_DATA = 3'b101,
		I2C_ACK_D = 3'b110
	} pdtc_i2c_t;
	typedef struct packed {
		logic stb;
		logic [7:0] addr;
		logic [7:0] data;
	} pdtc_wr_t;
endpackage : pdtc_pkg

/* design/pdtc_i2c.sv */
`timescale 1ns/10ps
module pdtc_i2c #(
	parameter logic [5:0] ADDR_HI = 6'h2a // arbitrary fixed address bits
) (
	// system
	input wire logic clk_in,
	input wire logic nrst_in,
	// pins
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic adr_sel_in,
	output logic sda_out,
	output logic sda_oe_n_out,
	// register writes
	output pdtc_pkg::pdtc_wr_t wr_out
);
	import pdtc_pkg::*;
	logic [2:0] scl_q;
	logic [2:0] sda_q;
	logic [1:0] adr_q;
	logic rise, fall, start, stop;
	logic [7:0] sh;
	logic [7:0] ptr;
	logic [3:0] cnt;
	pdtc_i2c_t state;

	////////////////////////////////////////////////////////////////
	// two flops per pin, third flop only for edge finding
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			scl_q <= 3'h7;
			sda_q <= 3'h7;
			adr_q <= 2'h0;
		end else begin
			scl_q <= {scl_q[1:0], scl_in};
			sda_q <= {sda_q[1:0], sda_in};
			adr_q <= {adr_q[0], adr_sel_in};
		end
	end

	assign rise = scl_q[1] & ~scl_q[2];
	assign fall = ~scl_q[1] & scl_q[2];
	assign start = scl_q[1] & scl_q[2] & sda_q[2] & ~sda_q[1];
	assign stop = scl_q[1] & scl_q[2] & ~sda_q[2] & sda_q[1];

	////////////////////////////////////////////////////////////////
	// write-only slave; a read address gets no ack and the bus is left alone
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			state <= I2C_IDLE;
			cnt <= 4'h0;
			sh <= 8'h00;
			ptr <= 8'h00;
			sda_oe_n_out <= 1'b1;
			sda_out <= 1'b0;
			wr_out <= '0;
		end else begin
			wr_out.stb <= 1'b0;
			if (stop) begin
				state <= I2C_IDLE;
				sda_oe_n_out <= 1'b1;
			end else if (start) begin
				state <= I2C_ADDR;
				cnt <= 4'h0;
				sda_oe_n_out <= 1'b1;
			end else if (rise && cnt != 4'h8 &&
					(state == I2C_ADDR || state == I2C_REG || state == I2C_DATA)) begin
				sh <= {sh[6:0], sda_q[1]};
				cnt <= 4'(cnt + 4'h1);
			end else if (fall) begin
				case (state)
					I2C_ADDR: begin
						// six fixed bits plus the select pin
						if (cnt == 4'h8 && sh == {ADDR_HI, adr_q[1], 1'b0}) begin
							sda_oe_n_out <= 1'b0;
							state <= I2C_ACK_A;
						end else if (cnt == 4'h8) begin
							state <= I2C_IDLE;
						end
					end
					I2C_REG: begin
						if (cnt == 4'h8) begin
							ptr <= sh;
							sda_oe_n_out <= 1'b0;
							state <= I2C_ACK_R;
						end
					end
					I2C_DATA: begin
						if (cnt == 4'h8) begin
							wr_out <= '{stb: 1'b1, addr: ptr, data: sh};
							ptr <= 8'(ptr + 8'h01);
							sda_oe_n_out <= 1'b0;
							state <= I2C_ACK_D;
						end
					end
					I2C_ACK_A: begin
						// ack held for the whole ninth pulse
						sda_oe_n_out <= 1'b1;
						cnt <= 4'h0;
						state <= I2C_REG;
					end
					I2C_ACK_R, I2C_ACK_D: begin
						sda_oe_n_out <= 1'b1;
						cnt <= 4'h0;
						state <= I2C_DATA;
					end
					default: begin
						state <= I2C_IDLE;
					end
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!nrst_in);
	property p_start;
		start && !stop |=> state == I2C_ADDR && cnt == 4'h0;
	endproperty
	a_start: assert property (p_start) else $error("start not taken");
	property p_stop;
		stop |=> state == I2C_IDLE && sda_oe_n_out;
	endproperty
	a_stop: assert property (p_stop) else $error("stop not taken");
	property p_ack;
		state == I2C_ACK_A || state == I2C_ACK_R || state == I2C_ACK_D |-> !sda_oe_n_out;
	endproperty
	a_ack: assert property (p_ack) else $error("ack released early");
	property p_match;
		$rose(state == I2C_ACK_A) |-> $past(sh) == {ADDR_HI, adr_q[1], 1'b0};
	endproperty
	a_match: assert property (p_match) else $error("ack on wrong address");
endmodule : pdtc_i2c

/* design/pdtc_top.sv */
`timescale 1ns/10ps
// How it works
// - supply above 4.5 V gives half bridge, back to full only below 4.4 V
// - charge control inserts an extra both-high state at the start of a full-bridge pulse when the position lands on its first tick
// - hybrid mode alternates full and half bridge by the speed ratio
// - period counts oscillator ticks of 0.04 us from nominal 25 MHz
// - sweep scans trims around the period and settles on the best one
// - incremental steps trim toward better performance, reversing on a drop
// - calibration moves only the oscillator trim, never the period count
// - calibration waits until both pulse-count registers were written
// - sda falling while scl high is a start
// - sda rising while scl high is a stop
// - bytes are eight bits, msb first, each followed by an ack
// - device pulls sda low through the master's ack pulse
// - write-only slave with byte write and page write
// - address is six fixed bits plus one bit from a pin
// - serial registers set direction, period, pulses, width, shift and hybrid share
// - calibrate select: 00 none, 01 incremental, 10 sweep, 11 reserved
// - half bridge enable only acts above the supply threshold
// - tracking works across 50 to 200 kHz drive frequency
module pdtc_top (
	// system
	input wire logic clk_in,
	input wire logic nrst_in,
	// serial pins
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic adr_sel_in,
	output logic sda_out,
	output logic sda_oe_n_out,
	// motor sense, same clock
	input wire logic [7:0] perf_in,
	// bridge legs {p2b, p2a, p1b, p1a}
	output logic [3:0] drv_out,
	// ahb-lite slave
	input wire logic hsel_in,
	input wire logic [31:0] haddr_in,
	input wire logic [1:0] htrans_in,
	input wire logic hwrite_in,
	input wire logic [2:0] hsize_in,
	input wire logic [31:0] hwdata_in,
	input wire logic hready_in,
	output logic [31:0] hrdata_out,
	output logic hreadyout_out,
	output logic hresp_out
);
	import pdtc_pkg::*;
	pdtc_wr_t wr;
	logic [7:0] regs [0:7];
	logic got_hi, got_lo, loaded;
	logic [12:0] cfg_mv;
	logic cfg_cc;
	logic hb_active, half_mode, run, in_range;
	logic [11:0] frac;
	logic [13:0] osc_sum;
	logic [1:0] ticks;
	logic [8:0] pos, pos2, next_pos, period;
	logic [9:0] pos_sum, pos2_sum;
	logic per_end;
	logic [10:0] remaining;
	logic [6:0] frame;
	pdtc_cn_t cn;
	pdtc_cal_t cal;
	logic signed [7:0] trim, best_trim;
	logic [7:0] best_perf, last_perf;
	logic inc_dir, cal_done, dwell_end;
	logic [3:0] dwell, steps;
	logic ap_wr;
	logic [7:0] ap_addr;

	pdtc_i2c u_i2c (
		.clk_in(clk_in),
		.nrst_in(nrst_in),
		.scl_in(scl_in),
		.sda_in(sda_in),
		.adr_sel_in(adr_sel_in),
		.sda_out(sda_out),
		.sda_oe_n_out(sda_oe_n_out),
		.wr_out(wr)
	);

	////////////////////////////////////////////////////////////////
	// serial register file; a fresh write of calibrate select beats the clear
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			for (int i = 0; i < 8; i++) begin
				regs[i] <= 8'h00;
			end
			regs[RI_CTRL] <= CTRL_RST;
			regs[RI_HYB] <= HYB_RST;
		end else begin
			if (wr.stb && wr.addr < REG_COUNT) begin
				regs[wr.addr[2:0]] <= wr.data;
			end
			// a write to another register must not swallow the disarm, else the run restarts
			if (cal_done && !(wr.stb && wr.addr == {5'h00, RI_CTRL})) begin
				regs[RI_CTRL][CTRL_CN_HI:CTRL_CN_LO] <= CN_NONE;
			end
		end
	end

	// both pulse-count bytes must have arrived
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			got_hi <= 1'b0;
			got_lo <= 1'b0;
		end else if (wr.stb) begin
			got_hi <= got_hi | (wr.addr == {5'h00, RI_PULSE_HI});
			got_lo <= got_lo | (wr.addr == {5'h00, RI_PULSE_LO});
		end
	end
	assign loaded = got_hi & got_lo;

	assign cn = pdtc_cn_t'(regs[RI_CTRL][CTRL_CN_HI:CTRL_CN_LO]);
	assign period = {regs[RI_PULSE_HI][PH_PER_MSB], regs[RI_PER_LO]};
	// tracking only inside the drive-frequency window
	assign in_range = period >= PER_MIN && period <= PER_MAX;
	assign run = remaining != 11'h000 && !regs[RI_OFFS][OFF_IDLE] && period != 9'h000;

	////////////////////////////////////////////////////////////////
	// oscillator model: fractional tick accumulator, up to two ticks per clock
	// trim moves the tick rate, the period count is untouched
	assign osc_sum = 14'({2'b00, frac} + OSC_INC_NOM + {{6{trim[7]}}, trim});
	assign ticks = osc_sum[13:12];
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			frac <= 12'h000;
		end else begin
			frac <= osc_sum[11:0];
		end
	end

	// position inside the drive period, in ticks
	always_comb begin
		pos_sum = {1'b0, pos} + {8'h00, ticks};
		per_end = 1'b0;
		next_pos = pos_sum[8:0];
		if (!run) begin
			next_pos = 9'h000;
		end else if (pos_sum >= {1'b0, period}) begin
			per_end = 1'b1;
			next_pos = 9'(pos_sum - {1'b0, period});
		end
		pos2_sum = {1'b0, pos} + {2'b00, regs[RI_SHIFT]};
		pos2 = pos2_sum[8:0];
		if (pos2_sum >= {1'b0, period}) begin
			pos2 = 9'(pos2_sum - {1'b0, period});
		end
	end

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			pos <= 9'h000;
		end else begin
			pos <= next_pos;
		end
	end

	// pulse count reloads on each low-byte write and runs down per period
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			remaining <= 11'h000;
		end else if (wr.stb && wr.addr == {5'h00, RI_PULSE_LO}) begin
			remaining <= {regs[RI_PULSE_HI][2:0], wr.data};
		end else if (per_end) begin
			remaining <= 11'(remaining - 11'h001);
		end
	end

	////////////////////////////////////////////////////////////////
	// supply hysteresis; only while enabled
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			hb_active <= 1'b0;
		end else if (!regs[RI_OFFS][OFF_HB]) begin
			hb_active <= 1'b0;
		end else if (cfg_mv > HB_RISE_MV) begin
			hb_active <= 1'b1;
		end else if (cfg_mv < HB_FALL_MV) begin
			hb_active <= 1'b0;
		end
	end

	// hybrid frame of 128 periods; speed value gives the full-bridge share
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			frame <= 7'h00;
		end else if (!run) begin
			frame <= 7'h00;
		end else if (per_end) begin
			frame <= 7'(frame + 7'h01);
		end
	end
	assign half_mode = hb_active |
		(regs[RI_OFFS][OFF_HYB] & ({1'b0, frame} >= regs[RI_HYB]));

	// one bridge leg pair {b, a} for a given position
	function automatic logic [1:0] leg(input logic [8:0] p, input logic [8:0] per,
			input logic [7:0] w, input logic half, input logic cc);
		logic [8:0] h;
		logic first;
		logic [8:0] off;
		h = per >> 1;
		first = p < h;
		off = first ? p : 9'(p - h);
		leg = 2'b00;
		// extra both-high state softens the leading edge of a full-bridge pulse whose first tick the position lands on
		if (cc && !half && w != 8'h00 && off == 9'h000) begin
			leg = 2'b11;
		end else if (off < {1'b0, w}) begin
			leg = first ? 2'b01 : (half ? 2'b00 : 2'b10);
		end
	endfunction : leg

	// drivers are pulled low when the motor is off; direction swaps phases
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			drv_out <= 4'h0;
		end else if (!run) begin
			drv_out <= 4'h0;
		end else begin
			drv_out[1:0] <= regs[RI_CTRL][CTRL_P1] ? leg(regs[RI_PULSE_HI][PH_DIR] ? pos2 : pos,
				period, regs[RI_WIDTH], half_mode, cfg_cc) : 2'b00;
			drv_out[3:2] <= regs[RI_CTRL][CTRL_P2] ? leg(regs[RI_PULSE_HI][PH_DIR] ? pos : pos2,
				period, regs[RI_WIDTH], half_mode, cfg_cc) : 2'b00;
		end
	end

	////////////////////////////////////////////////////////////////
	// calibration; trim may wander in incremental mode, bounded only by its width
	assign dwell_end = per_end && dwell == 4'(CAL_DWELL - 4'h1);
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			dwell <= 4'h0;
		end else if (cal == CAL_IDLE || dwell_end) begin
			dwell <= 4'h0;
		end else if (per_end) begin
			dwell <= 4'(dwell + 4'h1);
		end
	end

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			cal <= CAL_IDLE;
			trim <= 8'sh00;
			best_trim <= 8'sh00;
			best_perf <= 8'h00;
			last_perf <= 8'h00;
			inc_dir <= 1'b0;
			steps <= 4'h0;
			cal_done <= 1'b0;
		end else begin
			cal_done <= 1'b0;
			case (cal)
				CAL_IDLE: begin
					// start only when armed and in range
					if (loaded && in_range && !cal_done && cn == CN_SWEEP) begin
						cal <= CAL_SWEEP;
						trim <= -SWEEP_SPAN;
						best_perf <= 8'h00;
						best_trim <= 8'sh00;
					end else if (loaded && in_range && !cal_done && cn == CN_INC) begin
						cal <= CAL_INC;
						last_perf <= perf_in;
						steps <= 4'h0;
					end
				end
				CAL_SWEEP: begin
					// keep the best trim seen, settle on it at the end
					if (dwell_end) begin
						if (perf_in > best_perf) begin
							best_perf <= perf_in;
							best_trim <= trim;
						end
						if (trim >= SWEEP_SPAN) begin
							trim <= perf_in > best_perf ? trim : best_trim;
							cal <= CAL_IDLE;
							cal_done <= 1'b1;
						end else begin
							trim <= 8'(trim + CAL_STEP);
						end
					end
				end
				CAL_INC: begin
					if (dwell_end) begin
						inc_dir <= (perf_in < last_perf) ? ~inc_dir : inc_dir;
						trim <= ((perf_in < last_perf) ^ inc_dir) ?
							8'(trim - CAL_STEP) : 8'(trim + CAL_STEP);
						last_perf <= perf_in;
						steps <= 4'(steps + 4'h1);
						if (steps == 4'(INC_STEPS - 4'h1)) begin
							cal <= CAL_IDLE;
							cal_done <= 1'b1;
						end
					end
				end
				default: begin
					cal <= CAL_IDLE;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// ahb-lite slave, zero wait; read data is registered in the address phase
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			ap_wr <= 1'b0;
			ap_addr <= 8'h00;
			hrdata_out <= 32'h0000_0000;
			hreadyout_out <= 1'b1;
			hresp_out <= 1'b0;
		end else if (hready_in) begin
			ap_wr <= hsel_in & htrans_in[1] & hwrite_in;
			ap_addr <= haddr_in[7:0];
			if (hsel_in && htrans_in[1] && !hwrite_in && haddr_in[7:0] == AHB_STATUS) begin
				hrdata_out <= {5'h00, remaining, trim, 5'h00, run, cal != CAL_IDLE, hb_active};
			end else if (hsel_in && htrans_in[1] && !hwrite_in && haddr_in[7:0] == AHB_CONFIG) begin
				hrdata_out <= {15'h0000, cfg_cc, 3'h0, cfg_mv};
			end else begin
				hrdata_out <= 32'h0000_0000;
			end
		end
	end

	// supply reading and charge-control enable come from software
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			cfg_mv <= 13'h0000;
			cfg_cc <= 1'b0;
		end else if (ap_wr && ap_addr == AHB_CONFIG) begin
			cfg_mv <= hwdata_in[12:0];
			cfg_cc <= hwdata_in[CFG_CC];
		end
	end

	////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!nrst_in);
	property p_hb_rise;
		regs[RI_OFFS][OFF_HB] && cfg_mv > HB_RISE_MV |=> hb_active;
	endproperty
	a_hb_rise: assert property (p_hb_rise) else $error("no half bridge");
	property p_hb_hyst;
		hb_active && regs[RI_OFFS][OFF_HB] && cfg_mv >= HB_FALL_MV |=> hb_active;
	endproperty
	a_hb_hyst: assert property (p_hb_hyst) else $error("hysteresis lost");
	property p_hb_gate;
		!regs[RI_OFFS][OFF_HB] |=> !hb_active;
	endproperty
	a_hb_gate: assert property (p_hb_gate) else $error("half bridge not gated");
	property p_cc;
		drv_out[0] && drv_out[1] |-> $past(cfg_cc) && !$past(half_mode);
	endproperty
	a_cc: assert property (p_cc) else $error("stray both-high state");
	property p_hyb;
		run && regs[RI_OFFS][OFF_HYB] && regs[RI_HYB] == 8'h00 |=> !run || drv_out[1] == 1'b0;
	endproperty
	a_hyb: assert property (p_hyb) else $error("hybrid not half");
	property p_osc;
		trim == 8'sh00 |-> ticks != 2'b00;
	endproperty
	a_osc: assert property (p_osc) else $error("tick rate wrong");
	property p_cal_wait;
		cal == CAL_IDLE && (!loaded || !in_range) |=> cal == CAL_IDLE;
	endproperty
	a_cal_wait: assert property (p_cal_wait) else $error("early calibration");
	property p_cn_rsvd;
		cal == CAL_IDLE && (cn == CN_RSVD || cn == CN_NONE) |=> cal == CAL_IDLE;
	endproperty
	a_cn_rsvd: assert property (p_cn_rsvd) else $error("reserved code ran");
	property p_period_kept;
		cal != CAL_IDLE && !wr.stb |=> $stable(period);
	endproperty
	a_period_kept: assert property (p_period_kept) else $error("period moved");
	sequence s_sweep_last;
		cal == CAL_SWEEP && dwell_end && trim >= SWEEP_SPAN;
	endsequence
	property p_sweep_settle;
		s_sweep_last |=> cal == CAL_IDLE && cal_done &&
			trim == ($past(perf_in) > $past(best_perf) ? $past(trim) : $past(best_trim));
	endproperty
	a_sweep_settle: assert property (p_sweep_settle) else $error("sweep settle wrong");
	sequence s_inc_drop;
		cal == CAL_INC && dwell_end && perf_in < last_perf;
	endsequence
	property p_inc_reverse;
		s_inc_drop |=> inc_dir != $past(inc_dir) ##1 $stable(inc_dir);
	endproperty
	a_inc_reverse: assert property (p_inc_reverse) else $error("no reversal");
endmodule : pdtc_top

/* tb/pdtc_i2c_master.sv */
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// serial bus master model; open drain, so 1 releases the line to its pull-up
module pdtc_i2c_master (
	// resolved data line
	input wire logic sda_in,
	// driven lines
	output logic scl_out,
	output logic sda_out
);
	// idle bus: both lines released, clock stands high outside frames
	initial begin
		scl_out = 1'b1;
		sda_out = 1'b1;
	end
	task start;
		sda_out = 1'b1;
		#100 scl_out = 1'b1;
		#100 sda_out = 1'b0;
		#100 scl_out = 1'b0;
	endtask : start
	task stop;
		#100 sda_out = 1'b0;
		#100 scl_out = 1'b1;
		#100 sda_out = 1'b1;
		#100;
	endtask : stop
	task send(input logic [7:0] b, output logic ack);
		for (int i = 8; i >= 0; i--) begin
			// data moves a quarter period after the clock fell, never beside an scl edge
			#100 sda_out = (i > 0) ? b[i - 1] : 1'b1;
			#100 scl_out = 1'b1;
			#100 if (i == 0) ack = (sda_in === 1'b0);
			#100 scl_out = 1'b0;
		end
	endtask : send
endmodule : pdtc_i2c_master

/* tb/pdtc_top_tb.sv */
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
module pdtc_top_tb;
	import pdtc_pkg::*;
	logic clk_in, nrst_in, adr_sel_in, sda_out, sda_oe_n_out, hsel_in, hwrite_in;
	logic hreadyout_out, hresp_out, scl_w, sda_m, seen_cc, seen_full;
	logic [1:0] htrans_in;
	logic [2:0] hsize_in;
	logic [3:0] drv_out;
	logic [7:0] perf_in;
	logic [31:0] haddr_in, hwdata_in, hrdata_out, r;
	logic [12:0] mv [6] = '{13'd4500, 13'd4501, 13'd4450, 13'd4400, 13'd4399, 13'd4500};
	logic [5:0] hb_exp = 6'b001110;
	int fails, comparisons, n;
	// wired-and of both parties, pull-up when released
	wire logic sda_w = sda_m & (sda_oe_n_out | sda_out);
	pdtc_i2c_master mst (.sda_in(sda_w), .scl_out(scl_w), .sda_out(sda_m));
	pdtc_top DUT (.clk_in(clk_in), .nrst_in(nrst_in), .scl_in(scl_w), .sda_in(sda_w),
		.adr_sel_in(adr_sel_in), .sda_out(sda_out), .sda_oe_n_out(sda_oe_n_out),
		.perf_in(perf_in), .drv_out(drv_out), .hsel_in(hsel_in), .haddr_in(haddr_in),
		.htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsize_in(hsize_in),
		.hwdata_in(hwdata_in), .hready_in(hreadyout_out), .hrdata_out(hrdata_out),
		.hreadyout_out(hreadyout_out), .hresp_out(hresp_out));
	initial begin
		clk_in = 1'b0;
		forever #25 clk_in = ~clk_in;
	end
	// moving metric so tracking sees changes; both legs high marks charge control
	always @(posedge clk_in) begin
		perf_in <= perf_in + 8'h01;
		if (drv_out[1:0] === 2'b11 || drv_out[3:2] === 2'b11) seen_cc <= 1'b1;
		if (drv_out[1] === 1'b1 || drv_out[3] === 1'b1) seen_full <= 1'b1;
	end
	////////////////////////////////////////////////////////////////////////////////
	task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	// single word transfer, entered right after a rising edge
	task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
		hsel_in <= 1'b1;
		haddr_in <= a;
		hwrite_in <= w;
		htrans_in <= 2'h2;
		do @(posedge clk_in); while (hreadyout_out !== 1'b1);
		hsel_in <= 1'b0;
		htrans_in <= 2'h0;
		hwdata_in <= d;
		do @(posedge clk_in); while (hreadyout_out !== 1'b1);
		r = hrdata_out;
	endtask : ahb
	// one framed transfer; ends on a clock edge so bus calls may follow
	task i2c(input logic [7:0] q [$]);
		logic ack;
		n = 0;
		// keep every pin edge half a clock away from the sampling edge
		@(negedge clk_in);
		mst.start();
		foreach (q[i]) begin
			mst.send(q[i], ack);
			n += int'(ack);
		end
		mst.stop();
		@(posedge clk_in);
	endtask : i2c
	task final_report;
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : final_report
	// watchdog: the whole run needs well under half a millisecond
	initial begin
		#2000000;
		fails++;
		final_report();
	end
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		{nrst_in, hsel_in, hwrite_in, htrans_in, haddr_in, hwdata_in, perf_in} = '0;
		{fails, comparisons, seen_cc, seen_full} = '0;
		hsize_in = 3'h2;
		adr_sel_in = 1'b1;
		repeat (20) @(posedge clk_in);
		nrst_in <= 1'b1;
		repeat (4) @(posedge clk_in);
		ahb(1'b0, 32'(AHB_STATUS), 32'h0);
		check("status", r, 32'h0);
		check("response", hresp_out, 1'b0);
		ahb(1'b1, 32'h8, 32'hffffffff);
		ahb(1'b0, 32'h8, 32'h0);
		check("unmapped", r, 32'h0);
		// a supply above 5.0 V only while the motor stands
		ahb(1'b1, 32'(AHB_CONFIG), 32'hffffffff);
		ahb(1'b0, 32'(AHB_CONFIG), 32'h0);
		check("config", r, 32'h00011fff);
		$display("test registers done");
		i2c('{8'ha8});
		check("ack other address", n, 0);
		i2c('{8'hab});
		check("ack read", n, 0);
		i2c('{8'haa, 8'h10, 8'h55});
		check("ack reserved", n, 3);
		$display("test addressing done");
		i2c('{8'haa, {5'h0, RI_CTRL}, 8'h6b});
		check("ack control", n, 3);
		// period for the motor goes in before any pulse count
		i2c('{8'haa, {5'h0, RI_PER_LO}, 8'h94});
		ahb(1'b0, 32'(AHB_STATUS), 32'h0);
		check("cal held", r[1], 1'b0);
		ahb(1'b1, 32'(AHB_CONFIG), 32'h00010000);
		seen_cc = 1'b0;
		i2c('{8'haa, {5'h0, RI_PULSE_HI}, 8'h00, 8'h10, 8'h20, 8'h00, 8'h00});
		check("ack page", n, 7);
		ahb(1'b0, 32'(AHB_STATUS), 32'h0);
		check("cal busy", r[1], 1'b1);
		check("run", r[2], 1'b1);
		repeat (400) @(posedge clk_in);
		check("charge state", seen_cc, 1'b1);
		check("full bridge", seen_full, 1'b1);
		$display("test drive done");
		i2c('{8'haa, {5'h0, RI_OFFS}, 8'h40});
		for (int i = 0; i < 6; i++) begin
			ahb(1'b1, 32'(AHB_CONFIG), {19'h0, mv[i]});
			repeat (3) @(posedge clk_in);
			ahb(1'b0, 32'(AHB_STATUS), 32'h0);
			check("half bridge", r[0], hb_exp[i]);
		end
		ahb(1'b1, 32'(AHB_CONFIG), 32'h00001195);
		i2c('{8'haa, {5'h0, RI_OFFS}, 8'h00});
		ahb(1'b0, 32'(AHB_STATUS), 32'h0);
		check("half bridge off", r[0], 1'b0);
		$display("test supply done");
		// hybrid share of zero keeps every period half bridge; pulse count reloaded
		i2c('{8'haa, {5'h0, RI_PULSE_LO}, 8'h10, 8'h20, 8'h00, 8'h20, 8'h00});
		check("ack hybrid", n, 7);
		seen_full <= 1'b0;
		repeat (300) @(posedge clk_in);
		check("hybrid half", seen_full, 1'b0);
		ahb(1'b0, 32'(AHB_STATUS), 32'h0);
		check("hybrid run", r[2], 1'b1);
		$display("test hybrid done");
		final_report();
	end
endmodule : pdtc_top_tb
